// ==== src/part_regs.svh ====
// Register offsets, field positions and reset values of the PWM auto-reload timer.
// Assumes an 8-bit register port with byte-wide offsets.
`ifndef PART_REGS_SVH
`define PART_REGS_SVH

`define PART_ADDR_W         4
`define PART_OFF_DUTY3      4'h0
`define PART_OFF_DUTY2      4'h1
`define PART_OFF_DUTY1      4'h2
`define PART_OFF_DUTY0      4'h3
`define PART_OFF_PWMCTRL    4'h4
`define PART_OFF_CSR        4'h5
`define PART_OFF_CNT        4'h6
`define PART_OFF_RELOAD     4'h7
`define PART_OFF_CAPCSR     4'h8
`define PART_OFF_CAP1       4'h9
`define PART_OFF_CAP2       4'hA
`define PART_OFF_HALTCTL    4'hB
`define PART_BIT_SRC        7
`define PART_BIT_RUN        3
`define PART_BIT_FRL        2
`define PART_BIT_OIE        1
`define PART_BIT_OVF        0
`define PART_RST_BYTE       8'h00
`define PART_CNT_MAX        8'hFF

`endif

// ==== src/part_pkg.sv ====
// Types shared by the PWM auto-reload timer.
// Assumes the constants header supplies the numbers.
package part_pkg;
    typedef struct packed {
        logic       source_select;
        logic [2:0] clock_divide_select;
        logic       counter_run;
        logic       overflow_irq_enable;
    } part_csr_t;

    typedef struct packed {
        logic [3:0] output_enable_bit;
        logic [3:0] output_polarity_bit;
    } part_pwmctl_t;

    typedef struct packed {
        logic [1:0] capture_edge_select;
        logic [1:0] capture_irq_enable;
    } part_capctl_t;
endpackage : part_pkg

// ==== src/part_timer.sv ====
// PWM auto-reload timer: prescaler, 8-bit counter, four PWM channels, two captures.
// Assumes register port pins synchronous to clk; count and capture inputs synchronised here; halt state comes from a system input.
`include "part_regs.svh"
`timescale 1ns/10ps
`default_nettype none

// Function
// - 8-bit up counter increments on each prescaler output enable.
// - Overflow reloads counter from reload register; prescaler untouched.
// - 7-bit prescaler, divide by two to the divide select field.
// - Source select 0 takes CPU clock, 1 takes external clock.
// - Run bit clear freezes prescaler and counter.
// - Reset clears counter and prescaler and selects CPU clock.
// - Force reload with run, or counter write, clears prescaler.
// - Hidden compare shadows load from duty registers only at overflow.
// - Output enable bit drives each channel pin independently.
// - Common period is 256 minus reload counter clocks.
// - Overflow sets every pin to its polarity-defined level.
// - Counter equal compare returns the pin to the opposite level.
// - Overflow sets flag and irq when enabled; software clears.
// - External clock mode with divide select 0 flags after 256 minus reload events.
// - Selected capture edge copies counter and sets capture flag.
// - Capture register locked until read; read clears flag.
// - Capture irq pending while flag and enable set.
// - Edge per capture channel chosen by edge select bit.
// - In halt an enabled capture edge raises wake request.
// - PWM generation stops during halt.
// - Reading control status register clears overflow flag.
// - Force reload is write-only and reads zero.
// - Polarity 0: high up to compare; 1 inverted; immediate.
// - Edge select 0 falling, 1 rising.
module part_timer (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic [`PART_ADDR_W-1:0] addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [7:0]             rdata,
    input  wire logic                   halt_mode,
    input  wire logic                   external_count_clock,
    input  wire logic [1:0]             capture_input_pin,
    output logic      [3:0]             pwm_output_pin,
    output logic      [3:0]             pwm_output_oe,
    output logic                        overflow_irq,
    output logic      [1:0]             capture_irq,
    output logic                        wake_req
);
    logic [1:0] rst_sync_r;
    logic       rst_n;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rst_sync_r <= 2'h0;
        else       rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    part_pkg::part_csr_t    csr_r;
    part_pkg::part_pwmctl_t pwmctl_r;
    part_pkg::part_capctl_t capctl_r;
    logic [7:0]  duty_r [4];
    logic [7:0]  shadow_r [4];
    logic [7:0]  reload_r, cnt_r, cnt_nxt;
    logic [6:0]  pre_r, pre_nxt;
    logic        ovf_flag_r;
    logic [1:0]  cap_flag_r;
    logic [7:0]  cap_r [2];
    logic [3:0]  level_r;

    // Synchronisers: first stage read only by second stage
    logic [1:0] ext_s1_r, ext_s2_r, ext_s3_r;
    logic [1:0] cap_s1_r [2];
    logic [1:0] cap_s2_r [2];
    logic [1:0] cap_s3_r [2];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_r <= 2'h0;
            ext_s2_r <= 2'h0;
            ext_s3_r <= 2'h0;
        end else begin
            ext_s1_r <= {1'b0, external_count_clock};
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    wire ext_rise = ext_s2_r[0] & ~ext_s3_r[0];
    wire in_tick  = csr_r.source_select ? ext_rise : 1'b1;
    wire run      = csr_r.counter_run;
    wire [7:0] pre_plus = {1'b0, pre_r} + 8'h01;
    // Tap n fires when the low n bits of the prescaler are all ones
    wire [7:0] tap_mask = (8'h01 << csr_r.clock_divide_select) - 8'h01;
    wire       tap_hit  = ((pre_plus[6:0] & tap_mask[6:0]) == 7'h00);
    wire       cnt_en   = run & in_tick & tap_hit;
    wire       ovf_evt  = cnt_en & (cnt_r == `PART_CNT_MAX);

    wire wr_csr    = wr & (addr == `PART_OFF_CSR);
    wire wr_cnt    = wr & (addr == `PART_OFF_CNT);
    wire force_ld  = wr_csr & wdata[`PART_BIT_FRL] & wdata[`PART_BIT_RUN];
    wire rd_csr    = rd & (addr == `PART_OFF_CSR);

    always_comb begin
        cnt_nxt = cnt_r;
        pre_nxt = pre_r;
        if (wr_cnt) begin
            cnt_nxt = wdata;
            pre_nxt = 7'h00;
        end else if (force_ld) begin
            cnt_nxt = reload_r;
            pre_nxt = 7'h00;
        end else if (run & in_tick) begin
            pre_nxt = pre_plus[6:0];
            if (tap_hit)
                cnt_nxt = (cnt_r == `PART_CNT_MAX) ? reload_r : cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= `PART_RST_BYTE;
            pre_r <= 7'h00;
        end else begin
            cnt_r <= cnt_nxt;
            pre_r <= pre_nxt;
        end
    end

    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_r    <= '0;
            pwmctl_r <= '0;
            capctl_r <= '0;
            reload_r <= `PART_RST_BYTE;
        end else if (wr) begin
            if (addr == `PART_OFF_CSR)
                csr_r <= {wdata[7:3], wdata[`PART_BIT_OIE]};
            if (addr == `PART_OFF_PWMCTRL)
                pwmctl_r <= wdata;
            if (addr == `PART_OFF_RELOAD)
                reload_r <= wdata;
            if (addr == `PART_OFF_CAPCSR)
                capctl_r <= wdata[5:2];
        end
    end

    // Overflow flag: set wins over read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)       ovf_flag_r <= 1'b0;
        else if (ovf_evt) ovf_flag_r <= 1'b1;
        else if (rd_csr)  ovf_flag_r <= 1'b0;
    end

    // PWM channels
    wire pwm_run = ~halt_mode;
    wire pin_nxt_0;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pwm
            wire wr_duty = wr & (addr == (`PART_OFF_DUTY0 - 4'(g)));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    duty_r[g]   <= `PART_RST_BYTE;
                    shadow_r[g] <= `PART_RST_BYTE;
                    level_r[g]  <= 1'b1;
                end else begin
                    if (wr_duty) duty_r[g] <= wdata;
                    if (ovf_evt & pwm_run) begin
                        shadow_r[g] <= duty_r[g];
                        level_r[g]  <= 1'b1;
                    end else if (cnt_en & pwm_run & (cnt_nxt == shadow_r[g]) &
                                 (cnt_r != shadow_r[g])) begin
                        level_r[g] <= 1'b1;
                    end else if (cnt_en & pwm_run & (cnt_r == shadow_r[g])) begin
                        level_r[g] <= 1'b0;
                    end
                end
            end
            // Polarity applied after the level so a change acts at once
            wire pin_nxt = level_r[g] ^ pwmctl_r.output_polarity_bit[g];
            if (g == 0) begin : g_probe
                assign pin_nxt_0 = pin_nxt;
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pwm_output_pin[g] <= 1'b0;
                    pwm_output_oe[g]  <= 1'b0;
                end else begin
                    pwm_output_pin[g] <= pwm_output_oe[g] ? pin_nxt : 1'b0;
                    pwm_output_oe[g]  <= pwmctl_r.output_enable_bit[g] & pwm_run;
                end
            end
        end
    endgenerate

    // Capture channels
    logic [1:0] cap_edge;
    generate
        for (g = 0; g < 2; g++) begin : g_cap
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cap_s1_r[g] <= 2'h0;
                    cap_s2_r[g] <= 2'h0;
                    cap_s3_r[g] <= 2'h0;
                end else begin
                    cap_s1_r[g] <= {1'b0, capture_input_pin[g]};
                    cap_s2_r[g] <= cap_s1_r[g];
                    cap_s3_r[g] <= cap_s2_r[g];
                end
            end
            wire rise = cap_s2_r[g][0] & ~cap_s3_r[g][0];
            wire fall = ~cap_s2_r[g][0] & cap_s3_r[g][0];
            assign cap_edge[g] = capctl_r.capture_edge_select[g] ? rise : fall;
            wire rd_cap = rd & (addr == (`PART_OFF_CAP1 + 4'(g)));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cap_r[g]      <= `PART_RST_BYTE;
                    cap_flag_r[g] <= 1'b0;
                end else if (cap_edge[g] & ~cap_flag_r[g]) begin
                    cap_r[g]      <= cnt_r;
                    cap_flag_r[g] <= 1'b1;
                end else if (rd_cap) begin
                    cap_flag_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Readback
    logic [7:0] rd_mux;
    always_comb begin
        unique case (addr)
            `PART_OFF_DUTY3:   rd_mux = duty_r[3];
            `PART_OFF_DUTY2:   rd_mux = duty_r[2];
            `PART_OFF_DUTY1:   rd_mux = duty_r[1];
            `PART_OFF_DUTY0:   rd_mux = duty_r[0];
            `PART_OFF_PWMCTRL: rd_mux = pwmctl_r;
            `PART_OFF_CSR:     rd_mux = {csr_r[5:1], 1'b0, csr_r.overflow_irq_enable,
                                         ovf_flag_r};
            `PART_OFF_CNT:     rd_mux = cnt_r;
            `PART_OFF_RELOAD:  rd_mux = reload_r;
            `PART_OFF_CAPCSR:  rd_mux = {2'h0, capctl_r, cap_flag_r};
            `PART_OFF_CAP1:    rd_mux = cap_r[0];
            `PART_OFF_CAP2:    rd_mux = cap_r[1];
            default:           rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata        <= 8'h00;
            overflow_irq <= 1'b0;
            capture_irq  <= 2'h0;
            wake_req     <= 1'b0;
        end else begin
            rdata        <= rd ? rd_mux : 8'h00;
            overflow_irq <= ovf_flag_r & csr_r.overflow_irq_enable;
            capture_irq  <= cap_flag_r & capctl_r.capture_irq_enable;
            wake_req     <= halt_mode & |(cap_edge & capctl_r.capture_irq_enable);
        end
    end

    // Checks use the internal reset copy, so the synchroniser window is ignored
    // Register writes are excluded where they legally override the counter
    AST_OVF_SET: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_evt |=> ovf_flag_r)
        else $error("overflow flag not set");
    AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_evt && !wr && !rd |=> cnt_r == $past(reload_r))
        else $error("no reload");
    AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
        !run && !wr |=> $stable(cnt_r) && $stable(pre_r))
        else $error("not frozen");
    AST_PRE_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cnt |=> pre_r == 7'h00 && cnt_r == $past(wdata))
        else $error("prescaler kept");
    AST_SHADOW: assert property (@(posedge clk) disable iff (!rst_n)
        !ovf_evt |=> $stable(shadow_r[0]))
        else $error("shadow changed");
    AST_OVF_RDCLR: assert property (@(posedge clk) disable iff (!rst_n)
        rd_csr && !ovf_evt |=> !ovf_flag_r)
        else $error("flag not cleared");
    AST_CAP_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
        cap_flag_r[0] |=> $stable(cap_r[0]))
        else $error("capture overwritten");
    AST_CAP_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        cap_flag_r[1] && capctl_r.capture_irq_enable[1] |=> capture_irq[1])
        else $error("capture irq missing");
    AST_HALT_OE: assert property (@(posedge clk) disable iff (!rst_n)
        halt_mode |=> pwm_output_oe == 4'h0)
        else $error("pwm runs in halt");
    AST_FRL_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        rd_csr |=> rdata[`PART_BIT_FRL] == 1'b0)
        else $error("force reload reads one");
    AST_CNT_INC: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_en && !wr_cnt && !force_ld && !ovf_evt |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("counter did not advance");
    AST_PRE_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_evt && !wr_cnt && !force_ld |=> pre_r == $past(pre_plus[6:0]))
        else $error("prescaler disturbed by reload");
    AST_DIV0: assert property (@(posedge clk) disable iff (!rst_n)
        run && !csr_r.source_select && csr_r.clock_divide_select == 3'h0 |-> cnt_en)
        else $error("undivided clock skipped a tick");
    AST_SRC_EXT: assert property (@(posedge clk) disable iff (!rst_n)
        csr_r.source_select && !ext_rise |-> !cnt_en)
        else $error("count without external event");
    AST_FRL_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        force_ld |=> pre_r == 7'h00 && cnt_r == $past(reload_r))
        else $error("force reload ignored");
    AST_OE_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        !halt_mode |=> pwm_output_oe == $past(pwmctl_r.output_enable_bit))
        else $error("output enable wrong");
    AST_OVF_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_evt && !halt_mode |=> level_r == 4'hF)
        else $error("overflow level wrong");
    AST_CMP_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_en && !halt_mode && !ovf_evt && cnt_r == shadow_r[0] |=> !level_r[0])
        else $error("compare level wrong");
    AST_POL_PIN: assert property (@(posedge clk) disable iff (!rst_n)
        pwm_output_oe[0] |=> pwm_output_pin[0] == $past(pin_nxt_0))
        else $error("polarity not applied");
    AST_CAP_COPY: assert property (@(posedge clk) disable iff (!rst_n)
        cap_edge[0] && !cap_flag_r[0] |=> cap_flag_r[0] && cap_r[0] == $past(cnt_r))
        else $error("capture not taken");
    AST_CAP_RDCLR: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == `PART_OFF_CAP1 && !cap_edge[0] |=> !cap_flag_r[0])
        else $error("capture flag kept after read");
    AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
        halt_mode && cap_edge[1] && capctl_r.capture_irq_enable[1] |=> wake_req)
        else $error("no wake request");
    AST_EDGE_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        cap_edge[1] |-> cap_s2_r[1][0] == capctl_r.capture_edge_select[1])
        else $error("wrong capture edge");
    AST_OVF_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        ovf_flag_r && csr_r.overflow_irq_enable |=> overflow_irq)
        else $error("overflow irq missing");

    // Main scenarios that the bench is expected to reach
    COV_OVF: cover property (@(posedge clk) disable iff (!rst_n) ovf_evt);
    COV_FRL: cover property (@(posedge clk) disable iff (!rst_n) force_ld);
    COV_CAP: cover property (@(posedge clk) disable iff (!rst_n) cap_edge[0] && !cap_flag_r[0]);
    COV_EXT: cover property (@(posedge clk) disable iff (!rst_n) cnt_en && csr_r.source_select);
    COV_WAKE: cover property (@(posedge clk) disable iff (!rst_n) wake_req);
endmodule : part_timer

`default_nettype wire

// ==== sim/part_load_model.sv ====
// Far-side model: a PWM load on channel 0, two capture input drivers and an event clock source.
// Assumes the bench calls its tasks right after a rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module part_load_model (
    input  wire logic       clk,
    input  wire logic [3:0] pwm_output_pin,
    input  wire logic [3:0] pwm_output_oe,
    output var logic        external_count_clock,
    output var logic [1:0]  capture_input_pin
);
    int high_cnt = 0;

    initial begin
        external_count_clock = 1'b0;
        capture_input_pin    = 2'b10;
    end

    // Load on channel 0 only sees a level while the pin is driven
    always @(posedge clk) begin
        if ((pwm_output_oe[0] & pwm_output_pin[0]) === 1'b1) begin
            high_cnt <= high_cnt + 1;
        end
    end

    // Seven cycles per event keeps the source well below clk/2; idle low between bursts
    task automatic send_events(input int n);
        repeat (n) begin
            @(posedge clk) external_count_clock <= 1'b1;
            repeat (3) @(posedge clk);
            external_count_clock <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : send_events

    task automatic toggle_input(input int ch);
        @(posedge clk) capture_input_pin[ch] <= ~capture_input_pin[ch];
    endtask : toggle_input
endmodule : part_load_model
`default_nettype wire

// ==== sim/part_timer_tb_top.sv ====
// Self-checking bench for the PWM auto-reload timer; reads are scored from a queue.
// Assumes the load model sits on the pin side and the register port never stalls.
`include "part_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module part_timer_tb_top;
    logic                    clk, nrst, wr, rd, halt_mode, ext_clk, ovf_irq, wake;
    logic [`PART_ADDR_W-1:0] addr;
    logic [7:0]              wdata, rdata, r, d;
    logic [1:0]              cap_pin, cap_irq;
    logic [3:0]              pwm_pin, pwm_oe;
    logic                    rd_d = 1'b0;
    logic [7:0]              exp_q[$], msk_q[$];
    int                      n_errors = 0, n_checks = 0, c0, p;

    part_timer i_part_timer (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .halt_mode(halt_mode), .external_count_clock(ext_clk),
        .capture_input_pin(cap_pin), .pwm_output_pin(pwm_pin), .pwm_output_oe(pwm_oe),
        .overflow_irq(ovf_irq), .capture_irq(cap_irq), .wake_req(wake));
    part_load_model i_part_load_model (.clk(clk), .pwm_output_pin(pwm_pin),
        .pwm_output_oe(pwm_oe), .external_count_clock(ext_clk), .capture_input_pin(cap_pin));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_checks++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d === 1'b1) begin
            if (exp_q.size() == 0) check(rdata, 32'hFFFF_FFFF, 32'hFF);
            else check(rdata, exp_q.pop_front(), msk_q.pop_front());
        end
    end

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    task automatic wait_cond(input int sel, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk);
            if ((sel == 0 && ovf_irq === 1'b1) || (sel == 1 && cap_irq === 2'b11)
                || (sel == 2 && wake === 1'b1)) break;
        end
        if (i == lim) begin
            n_errors++;
            report_and_stop();
        end
    endtask : wait_cond

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        halt_mode = 1'b0;
        void'($urandom(3));
        wdata = 8'($urandom);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 12; a++) rd_reg((a == 11) ? 4'hC : a[3:0], 8'h00, 8'hFF);
        // Random period and duty, duty kept above reload so a pulse exists
        r = 8'hE0 + 8'($urandom % 8);
        d = r + 8'd1 + 8'($urandom % 16);
        p = 256 - int'(r);
        wr_reg(`PART_OFF_RELOAD, r);
        wr_reg(`PART_OFF_DUTY0, d);
        wr_reg(`PART_OFF_PWMCTRL, 8'h10);
        wr_reg(`PART_OFF_CSR, 8'h0C);
        rd_reg(`PART_OFF_CSR, 8'h08, 8'hFE);
        repeat (200) @(posedge clk);
        check(pwm_oe, 32'h1, 32'hF);
        c0 = i_part_load_model.high_cnt;
        repeat (10 * p) @(posedge clk);
        check(i_part_load_model.high_cnt - c0, 10 * (d - r + 1), '1);
        wr_reg(`PART_OFF_PWMCTRL, 8'h11);
        repeat (4) @(posedge clk);
        c0 = i_part_load_model.high_cnt;
        repeat (10 * p) @(posedge clk);
        check(i_part_load_model.high_cnt - c0, 10 * (p - (d - r + 1)), '1);
        wr_reg(`PART_OFF_CSR, 8'h0E);
        wait_cond(0, 64);
        wr_reg(`PART_OFF_CSR, 8'h02);
        rd_reg(`PART_OFF_CSR, 8'h03, 8'hFF);
        rd_reg(`PART_OFF_CSR, 8'h02, 8'hFF);
        halt_mode <= 1'b1;
        repeat (4) @(posedge clk);
        check(pwm_oe, 32'h0, 32'hF);
        wr_reg(`PART_OFF_CNT, 8'h42);
        repeat (20) @(posedge clk);
        rd_reg(`PART_OFF_CNT, 8'h42, 8'hFF);
        // Channel 1 on rising, channel 2 on falling, both interrupts on
        wr_reg(`PART_OFF_CAPCSR, 8'h1C);
        i_part_load_model.toggle_input(0);
        wait_cond(2, 16);
        i_part_load_model.toggle_input(1);
        wait_cond(1, 16);
        rd_reg(`PART_OFF_CAPCSR, 8'h1F, 8'hFF);
        wr_reg(`PART_OFF_CNT, 8'h55);
        i_part_load_model.toggle_input(0);
        i_part_load_model.toggle_input(0);
        repeat (8) @(posedge clk);
        rd_reg(`PART_OFF_CAP1, 8'h42, 8'hFF);
        rd_reg(`PART_OFF_CAPCSR, 8'h1E, 8'hFF);
        rd_reg(`PART_OFF_CAP2, 8'h42, 8'hFF);
        repeat (4) @(posedge clk);
        check(cap_irq, 32'h0, 32'h3);
        // Counter stopped before leaving halt so no stray events land
        halt_mode <= 1'b0;
        wr_reg(`PART_OFF_RELOAD, 8'hFD);
        wr_reg(`PART_OFF_CNT, 8'hFD);
        wr_reg(`PART_OFF_CSR, 8'h8A);
        i_part_load_model.send_events(2);
        repeat (6) @(posedge clk);
        check(ovf_irq, 32'h0, 32'h1);
        i_part_load_model.send_events(1);
        wait_cond(0, 16);
        wr_reg(`PART_OFF_CSR, 8'h82);
        rd_reg(`PART_OFF_CSR, 8'h83, 8'hFF);
        rd_reg(`PART_OFF_CNT, 8'hFD, 8'hFF);
        // Fourteen prescaled ticks per tap; a few bus cycles of slack fit the mask
        wr_reg(`PART_OFF_RELOAD, 8'h00);
        for (int t = 2; t < 8; t++) begin
            wr_reg(`PART_OFF_CNT, 8'h00);
            wr_reg(`PART_OFF_CSR, {1'b0, 3'(t), 4'h8});
            repeat (14 << t) @(posedge clk);
            wr_reg(`PART_OFF_CSR, 8'h00);
            rd_reg(`PART_OFF_CNT, 8'h0C, 8'hFC);
        end
        repeat (4) @(posedge clk);
        report_and_stop();
    end
endmodule : part_timer_tb_top
`default_nettype wire
